// *** verification/acf_host_model.sv ***
// acf_host_model.sv: host side of the link byte layer, link clock domain
`default_nettype none
module acf_host_model (
	// link clock
	input wire logic link_clk,
	// requests towards the device
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic start_stop,
	output logic rd_req,
	// read answer
	input wire logic rd_ack,
	input wire logic rd_nak,
	input wire acf_pkg::acf_block_t rd_block
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		start_stop = 1'b0;
		rd_req = 1'b0;
	end
	// checksum step, bit 0 of the byte first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (b[i] != r[15]) r = {r[14:0], 1'b0} ^ 16'h8005;
			else r = {r[14:0], 1'b0};
		end
		return r;
	endfunction
	// one byte pulse, then a gap wider than the holding register needs
	task automatic send_byte(input logic [7:0] b);
		@(negedge link_clk);
		rx_byte <= b;
		rx_valid <= 1'b1;
		@(negedge link_clk);
		rx_valid <= 1'b0;
		rx_byte <= ~b; // released data does not keep its value
		repeat (4) @(negedge link_clk);
	endtask
	// frame a packet; bad spoils the checksum, cut stops early
	task automatic send_block(input logic [7:0] pkt[$], input logic bad, input int cut);
		logic [7:0] blk[$];
		logic [15:0] c;
		blk = pkt;
		blk.push_front(8'(pkt.size() + 3)); // count covers itself and checksum
		c = 16'h0000;
		foreach (blk[i]) c = crc_step(c, blk[i]);
		if (bad) c = ~c;
		blk.push_back(c[7:0]); // low byte goes first
		blk.push_back(c[15:8]);
		foreach (blk[i]) begin // block bytes below index cut, all sent before any read
			if (i < cut) send_byte(blk[i]);
		end
	endtask
	// one read; {ack, nak} and the block taken while the one-cycle answer stands
	task automatic read_block(output logic [1:0] an, output acf_pkg::acf_block_t b);
		@(negedge link_clk);
		rd_req <= 1'b1;
		@(negedge link_clk);
		an = {rd_ack, rd_nak};
		b = rd_block;
		rd_req <= 1'b0;
	endtask
	// poll until a block is granted, within a bound
	task automatic poll_block(output logic [1:0] an, output acf_pkg::acf_block_t b);
		for (int i = 0; i < 40; i++) begin
			read_block(an, b);
			if (an === 2'b10) break;
		end
	endtask
	// one start or stop condition
	task automatic start_stop_pulse();
		@(negedge link_clk);
		start_stop <= 1'b1;
		@(negedge link_clk);
		start_stop <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_auth_command_frontend.sv ***
// tb_auth_command_frontend.sv: self-checking bench of the command front end
`default_nettype none
module tb_auth_command_frontend;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 20;
	localparam int GAP = 200;
	localparam int WDOG = 8000;
	// stimulus and observed signals
	logic CLK_SYS = 1'b0, RST_B = 1'b0, LINK_CLK = 1'b0, WAKE_TOKEN = 1'b0, I2C_MODE = 1'b0;
	logic EXEC_DONE = 1'b0;
	logic [7:0] EXEC_STATUS = 8'h00;
	logic LINK_RX_VALID, LINK_START_STOP, LINK_RD_REQ, LINK_RD_ACK, LINK_RD_NAK;
	logic LINK_BUSY, EXEC_REQ, ASLEEP;
	logic [7:0] LINK_RX_BYTE;
	acf_pkg::acf_block_t LINK_RD_BLOCK;
	acf_pkg::acf_exec_t EXEC_CMD, exp;
	logic [7:0] pkt[$];
	logic [7:0] p1;
	int n_mismatch = 0;
	int num_checks = 0;
	// ordinary commands: opcode, decoded command, datapath status
	typedef struct {logic [7:0] op; acf_pkg::acf_cmd_t cmd; logic [7:0] st;} acf_row_t;
	acf_row_t rows[13] = '{
		'{8'h1C, acf_pkg::KEY_DERIVATION_CMD, 8'h00},
		'{8'h30, acf_pkg::REVISION_QUERY_CMD, 8'h01},
		'{8'h15, acf_pkg::DIGEST_GENERATION_CMD, 8'h0F},
		'{8'h11, acf_pkg::HMAC_RESP_CMD, 8'h00},
		'{8'h28, acf_pkg::MAC_VERIFY_CMD, 8'h01},
		'{8'h17, acf_pkg::ZONE_LOCK_CMD, 8'h0F},
		'{8'h08, acf_pkg::MAC_RESP_CMD, 8'h00},
		'{8'h16, acf_pkg::NONCE_GEN_CMD, 8'h01},
		'{8'h01, acf_pkg::IDLE_SELECT_CMD, 8'h0F},
		'{8'h1B, acf_pkg::RANDOM_GEN_CMD, 8'h00},
		'{8'h02, acf_pkg::WORD_READ_CMD, 8'h01},
		'{8'h12, acf_pkg::WORD_WRITE_CMD, 8'h0F},
		'{8'h20, acf_pkg::CONFIG_EXTRA_UPDATE_CMD, 8'h00}};
	// core clock, link clock offset in phase
	always #10 CLK_SYS = ~CLK_SYS;
	initial begin
		#3;
		forever #24 LINK_CLK = ~LINK_CLK;
	end
	// device under test, long counts shortened
	acf_frontend #(.CYC_PER_MS(MS), .BYTE_GAP_CYC(GAP), .AWAKE_LIMIT_CYC(WDOG)) uut (
		.CLK_SYS(CLK_SYS), .RST_B(RST_B), .LINK_CLK(LINK_CLK),
		.LINK_RX_VALID(LINK_RX_VALID), .LINK_RX_BYTE(LINK_RX_BYTE),
		.LINK_START_STOP(LINK_START_STOP), .LINK_RD_REQ(LINK_RD_REQ),
		.LINK_RD_ACK(LINK_RD_ACK), .LINK_RD_NAK(LINK_RD_NAK), .LINK_RD_BLOCK(LINK_RD_BLOCK),
		.LINK_BUSY(LINK_BUSY), .WAKE_TOKEN(WAKE_TOKEN), .I2C_MODE(I2C_MODE),
		.EXEC_REQ(EXEC_REQ), .EXEC_CMD(EXEC_CMD), .EXEC_DONE(EXEC_DONE),
		.EXEC_STATUS(EXEC_STATUS), .ASLEEP(ASLEEP));
	// host on the link
	acf_host_model host (
		.link_clk(LINK_CLK), .rx_valid(LINK_RX_VALID), .rx_byte(LINK_RX_BYTE),
		.start_stop(LINK_START_STOP), .rd_req(LINK_RD_REQ), .rd_ack(LINK_RD_ACK),
		.rd_nak(LINK_RD_NAK), .rd_block(LINK_RD_BLOCK));
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	// compare of a single level
	task automatic chk1(input logic got, input logic exp1, input string m);
		num_checks++;
		if (got !== exp1) fail(m);
	endtask
	// compare of the command handed to the datapaths
	task automatic chk_cmd(input acf_pkg::acf_exec_t got, input acf_pkg::acf_exec_t e, input string m);
		num_checks++;
		if (got !== e) fail(m);
	endtask
	// compare of a refused read
	task automatic chk_nak(input string m);
		logic [1:0] an;
		acf_pkg::acf_block_t b;
		host.read_block(an, b);
		num_checks++;
		if (an !== 2'b01) fail(m);
	endtask
	// compare of a granted 4-byte status block, checksum worked out here
	task automatic chk_rsp(input logic [7:0] st, input string m);
		logic [1:0] an;
		acf_pkg::acf_block_t b, e;
		logic [15:0] c;
		host.poll_block(an, b);
		c = host.crc_step(host.crc_step(16'h0000, 8'h04), st);
		e = {c[15:8], c[7:0], st, 8'h04};
		num_checks++;
		if (an !== 2'b10) begin
			fail(m);
			tally_and_finish();
		end
		if (b !== e) fail(m);
	endtask
	// bounded wait: 0 request up, 1 asleep, 2 awake
	task automatic wait_for(input int sel, input int lim, input string m);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge CLK_SYS);
			if (sel == 0 && EXEC_REQ === 1'b1) break;
			if (sel == 1 && ASLEEP === 1'b1) break;
			if (sel == 2 && ASLEEP === 1'b0) break;
		end
		if (i == lim) begin
			fail(m);
			tally_and_finish();
		end
	endtask
	// main sequence
	initial begin
		repeat (16) @(negedge CLK_SYS);
		chk1(ASLEEP, 1'b1, "not asleep in reset");
		chk1(EXEC_REQ, 1'b0, "request in reset");
		RST_B = 1'b1;
		repeat (4) @(negedge CLK_SYS);
		chk_nak("read before wake granted");
		@(negedge CLK_SYS);
		WAKE_TOKEN = 1'b1;
		wait_for(2, 50, "no wake");
		chk_rsp(8'h11, "wake block");
		$display("test reset and wake done");
		foreach (rows[k]) begin
			p1 = 8'hA0 + 8'(k);
			pkt = {rows[k].op, p1, 8'h34, 8'h12};
			host.send_block(pkt, 1'b0, 99);
			wait_for(0, 100, "no execution");
			exp = '{rows[k].cmd, rows[k].op, p1, 16'h1234};
			chk_cmd(EXEC_CMD, exp, "decode");
			repeat (4) @(negedge LINK_CLK);
			chk1(LINK_BUSY, 1'b1, "not busy");
			chk_nak("read while busy granted");
			@(negedge CLK_SYS);
			EXEC_STATUS = rows[k].st;
			EXEC_DONE = 1'b1;
			@(negedge CLK_SYS);
			EXEC_DONE = 1'b0;
			chk_rsp(rows[k].st, "status block");
		end
		$display("test command table done");
		host.send_block('{8'h30, 8'h00, 8'h00, 8'h00}, 1'b0, 99);
		wait_for(0, 100, "no execution");
		chk_rsp(8'h0F, "busy limit");
		host.send_block('{8'h1C, 8'h00, 8'h00, 8'h00}, 1'b1, 99);
		chk_rsp(8'hFF, "bad checksum");
		host.send_block('{8'h7E, 8'h00, 8'h00, 8'h00}, 1'b1, 99);
		chk_rsp(8'hFF, "checksum before parse");
		host.send_block('{8'h30}, 1'b0, 99);
		chk_rsp(8'h03, "short block");
		host.send_block('{8'h7E, 8'h00, 8'h00, 8'h00}, 1'b0, 99);
		chk_rsp(8'h03, "unknown opcode");
		host.send_byte(8'h55);
		chk_rsp(8'hFF, "count out of range");
		$display("test error codes done");
		host.send_block('{8'h02, 8'h00, 8'h00, 8'h00}, 1'b0, 3);
		chk_nak("mid block read granted");
		wait_for(1, GAP + 100, "no byte gap sleep");
		$display("test byte gap done");
		@(negedge CLK_SYS);
		WAKE_TOKEN = 1'b0;
		I2C_MODE = 1'b1;
		repeat (4) @(negedge CLK_SYS);
		WAKE_TOKEN = 1'b1;
		wait_for(2, 50, "no second wake");
		chk_rsp(8'h11, "second wake block");
		host.send_block('{8'h02, 8'h00, 8'h00, 8'h00}, 1'b0, 3);
		repeat (GAP + 100) @(negedge CLK_SYS);
		chk1(ASLEEP, 1'b0, "byte gap sleep in i2c");
		chk_nak("mid block read granted");
		host.start_stop_pulse();
		chk_rsp(8'h11, "start stop abort");
		$display("test i2c partial block done");
		wait_for(1, WDOG, "no watchdog sleep");
		repeat (4) @(negedge CLK_SYS);
		chk_nak("read after watchdog granted");
		$display("test watchdog done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** verilog/acf_cfg.svh ***
// acf_cfg.svh: constants of the authentication command front end
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH
`default_nettype none
// clock and time base
`define ACF_CLK_HZ 50000000
`define ACF_MS_PER_S 1000
// opcodes
`define ACF_OP_KEY_DERIVE 8'h1C
`define ACF_OP_REV_QUERY 8'h30
`define ACF_OP_DIGEST_GEN 8'h15
`define ACF_OP_HMAC_RESP 8'h11
`define ACF_OP_MAC_VERIFY 8'h28
`define ACF_OP_ZONE_LOCK 8'h17
`define ACF_OP_MAC_RESP 8'h08
`define ACF_OP_NONCE_GEN 8'h16
`define ACF_OP_IDLE_SELECT 8'h01
`define ACF_OP_RANDOM_GEN 8'h1B
`define ACF_OP_WORD_READ 8'h02
`define ACF_OP_WORD_WRITE 8'h12
`define ACF_OP_EXTRA_UPDATE 8'h20
// status codes of 4-byte blocks
`define ACF_ST_SUCCESS 8'h00
`define ACF_ST_MISCOMPARE 8'h01
`define ACF_ST_PARSE 8'h03
`define ACF_ST_EXEC 8'h0F
`define ACF_ST_WAKE 8'h11
`define ACF_ST_COMM 8'hFF
// block framing
`define ACF_CNT_STATUS 8'h04
`define ACF_CNT_MIN 8'h04
`define ACF_CNT_MAX 8'h54
`define ACF_CNT_CMD_MIN 8'h07
`define ACF_CRC_POLY 16'h8005
`define ACF_CRC_INIT 16'h0000
// longest busy times, ms
`define ACF_T_KEY_DERIVE_MS 62
`define ACF_T_REV_QUERY_MS 2
`define ACF_T_DIGEST_GEN_MS 43
`define ACF_T_HMAC_RESP_MS 69
`define ACF_T_MAC_VERIFY_MS 38
`define ACF_T_ZONE_LOCK_MS 24
`define ACF_T_MAC_RESP_MS 35
`define ACF_T_NONCE_GEN_MS 60
`define ACF_T_IDLE_SELECT_MS 2
`define ACF_T_RANDOM_GEN_MS 50
`define ACF_T_WORD_READ_MS 4
`define ACF_T_EXTRA_UPDATE_MS 12
`define ACF_T_WORD_WRITE_MS 42
// byte gap timeout and awake time limit, ms
`define ACF_BYTE_GAP_MS 50
`define ACF_AWAKE_LIMIT_MS 1000
`default_nettype wire
`endif

// *** verilog/acf_crc16_byte.sv ***
// acf_crc16_byte.sv: one byte step of the block checksum
`include "acf_cfg.svh"
`default_nettype none
module acf_crc16_byte (
	// running value
	input wire logic [15:0] crc_in,
	// byte, bit 0 first
	input wire logic [7:0] data_in,
	// updated value
	output logic [15:0] crc_out
);
	// bitwise shift with feedback, lsb of the byte first
	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 0; i < 8; i++) begin
			if (data_in[i] ^ c[15]) begin
				c = {c[14:0], 1'b0} ^ `ACF_CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

// *** verilog/acf_frontend.sv ***
// acf_frontend.sv: block framing, busy control and status blocks of the front end
`include "acf_cfg.svh"
`default_nettype none
module acf_frontend #(
	parameter int unsigned CYC_PER_MS = `ACF_CLK_HZ / `ACF_MS_PER_S,
	parameter int unsigned BYTE_GAP_CYC = `ACF_BYTE_GAP_MS * CYC_PER_MS,
	parameter int unsigned AWAKE_LIMIT_CYC = `ACF_AWAKE_LIMIT_MS * CYC_PER_MS
) (
	// core clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// link clock and link byte layer
	input wire logic LINK_CLK,
	input wire logic LINK_RX_VALID,
	input wire logic [7:0] LINK_RX_BYTE,
	input wire logic LINK_START_STOP,
	input wire logic LINK_RD_REQ,
	output logic LINK_RD_ACK,
	output logic LINK_RD_NAK,
	output acf_pkg::acf_block_t LINK_RD_BLOCK,
	output logic LINK_BUSY,
	// asynchronous wake token and mode strap
	input wire logic WAKE_TOKEN,
	input wire logic I2C_MODE,
	// command datapaths
	output logic EXEC_REQ,
	output acf_pkg::acf_exec_t EXEC_CMD,
	input wire logic EXEC_DONE,
	input wire logic [7:0] EXEC_STATUS,
	// power state
	output logic ASLEEP
);
	// refuse counts the logic cannot serve
	if (CYC_PER_MS == 0 || BYTE_GAP_CYC == 0 || AWAKE_LIMIT_CYC == 0) begin : g_bad_par
		$error("acf_frontend: cycle counts must be at least one");
	end

	// link domain state
	logic rx_tgl_r; // toggles per accepted byte
	logic [7:0] rx_hold_r; // last accepted byte
	logic ss_tgl_r; // toggles per start/stop condition
	logic [1:0] busy_l_r; // busy level synchroniser
	logic [1:0] ready_l_r; // response ready synchroniser
	wire busy_s = busy_l_r[1];
	wire ready_s = ready_l_r[1];
	wire rd_ok = LINK_RD_REQ && ready_s && !busy_s;

	// core domain state
	acf_pkg::acf_state_t st_r, st_nxt;
	logic [2:0] rx_sync_r; // byte toggle synchroniser plus edge stage
	logic [2:0] ss_sync_r; // start/stop toggle synchroniser
	logic [2:0] wake_sync_r; // wake level synchroniser
	logic [1:0] mode_sync_r; // mode strap synchroniser
	logic [31:0] wdog_r; // awake time counter
	logic [31:0] gap_r; // byte gap counter
	logic [31:0] lim_r; // busy time counter
	logic [6:0] idx_r; // position of next byte in the block
	logic [7:0] cnt_r; // count byte of the block
	logic [15:0] crc_r; // running checksum
	logic [7:0] crc_lo_r; // received low checksum byte
	logic crc_bad_r; // integrity or count failure
	logic [7:0] opc_r; // opcode byte
	logic [7:0] p1_r; // first_parameter
	logic [15:0] p2_r; // second_parameter
	acf_pkg::acf_block_t outb_r; // shared output buffer
	logic outv_r; // buffer holds a block
	logic busy_r; // busy level to the link
	logic ready_r; // block may be read

	// link-side crossings in: busy and ready levels
	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			busy_l_r <= 2'h0;
			ready_l_r <= 2'h0;
		end else begin
			busy_l_r <= {busy_l_r[0], busy_r};
			ready_l_r <= {ready_l_r[0], ready_r};
		end
	end

	// link-side byte and condition capture, dropped while busy
	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_tgl_r <= 1'b0;
			rx_hold_r <= 8'h00;
			ss_tgl_r <= 1'b0;
		end else begin
			if (LINK_RX_VALID && !busy_s) begin
				rx_hold_r <= LINK_RX_BYTE;
				rx_tgl_r <= ~rx_tgl_r;
			end
			if (LINK_START_STOP && !busy_s) begin
				ss_tgl_r <= ~ss_tgl_r;
			end
		end
	end

	// link-side read answer: block only when ready and not busy
	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			LINK_RD_ACK <= 1'b0;
			LINK_RD_NAK <= 1'b0;
			LINK_RD_BLOCK <= '0;
			LINK_BUSY <= 1'b0;
		end else begin
			LINK_RD_ACK <= rd_ok;
			LINK_RD_NAK <= LINK_RD_REQ && !rd_ok;
			LINK_BUSY <= busy_s;
			if (rd_ok) begin
				LINK_RD_BLOCK <= outb_r; // stable while ready is high
			end
		end
	end

	// core-side synchronisers; the first stage feeds only the second
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rx_sync_r <= 3'h0;
			ss_sync_r <= 3'h0;
			wake_sync_r <= 3'h0;
			mode_sync_r <= 2'h0;
		end else begin
			rx_sync_r <= {rx_sync_r[1:0], rx_tgl_r};
			ss_sync_r <= {ss_sync_r[1:0], ss_tgl_r};
			wake_sync_r <= {wake_sync_r[1:0], WAKE_TOKEN};
			mode_sync_r <= {mode_sync_r[0], I2C_MODE};
		end
	end

	// event decode
	wire rx_evt = rx_sync_r[2] ^ rx_sync_r[1];
	wire ss_evt = ss_sync_r[2] ^ ss_sync_r[1];
	wire wake_rise = wake_sync_r[1] && !wake_sync_r[2];
	wire i2c_mode = mode_sync_r[1];
	wire in_sleep = (st_r == acf_pkg::ST_SLEEP);
	wire in_idle = (st_r == acf_pkg::ST_IDLE);
	wire in_recv = (st_r == acf_pkg::ST_RECV);
	wire in_check = (st_r == acf_pkg::ST_CHECK);
	wire in_exec = (st_r == acf_pkg::ST_EXEC);

	// timers
	wire wdog_exp = !in_sleep && (wdog_r == 32'(AWAKE_LIMIT_CYC - 1));
	wire gap_exp = in_recv && !i2c_mode && (gap_r == 32'(BYTE_GAP_CYC - 1));

	// block position decode
	wire [7:0] pos = {1'b0, idx_r};
	wire cnt_bad = (rx_hold_r < `ACF_CNT_MIN) || (rx_hold_r > `ACF_CNT_MAX);
	wire in_packet = (pos <= cnt_r - 8'h03);
	wire at_crc_lo = (pos == cnt_r - 8'h02);
	wire blk_done = in_recv && rx_evt && (pos == cnt_r - 8'h01);
	wire [15:0] rx_crc_in = in_idle ? `ACF_CRC_INIT : crc_r;
	wire [15:0] rx_crc_out;
	acf_crc16_byte u_rx_crc (
		.crc_in(rx_crc_in),
		.data_in(rx_hold_r),
		.crc_out(rx_crc_out)
	);

	// opcode decode
	wire acf_pkg::acf_cmd_t dec_cmd =
		(opc_r == `ACF_OP_KEY_DERIVE) ? acf_pkg::KEY_DERIVATION_CMD :
		(opc_r == `ACF_OP_REV_QUERY) ? acf_pkg::REVISION_QUERY_CMD :
		(opc_r == `ACF_OP_DIGEST_GEN) ? acf_pkg::DIGEST_GENERATION_CMD :
		(opc_r == `ACF_OP_HMAC_RESP) ? acf_pkg::HMAC_RESP_CMD :
		(opc_r == `ACF_OP_MAC_VERIFY) ? acf_pkg::MAC_VERIFY_CMD :
		(opc_r == `ACF_OP_ZONE_LOCK) ? acf_pkg::ZONE_LOCK_CMD :
		(opc_r == `ACF_OP_MAC_RESP) ? acf_pkg::MAC_RESP_CMD :
		(opc_r == `ACF_OP_NONCE_GEN) ? acf_pkg::NONCE_GEN_CMD :
		(opc_r == `ACF_OP_IDLE_SELECT) ? acf_pkg::IDLE_SELECT_CMD :
		(opc_r == `ACF_OP_RANDOM_GEN) ? acf_pkg::RANDOM_GEN_CMD :
		(opc_r == `ACF_OP_WORD_READ) ? acf_pkg::WORD_READ_CMD :
		(opc_r == `ACF_OP_WORD_WRITE) ? acf_pkg::WORD_WRITE_CMD :
		(opc_r == `ACF_OP_EXTRA_UPDATE) ? acf_pkg::CONFIG_EXTRA_UPDATE_CMD :
		acf_pkg::UNKNOWN_CMD;

	// longest busy time of the running command, ms
	wire [31:0] lim_ms =
		(EXEC_CMD.cmd == acf_pkg::KEY_DERIVATION_CMD) ? `ACF_T_KEY_DERIVE_MS :
		(EXEC_CMD.cmd == acf_pkg::REVISION_QUERY_CMD) ? `ACF_T_REV_QUERY_MS :
		(EXEC_CMD.cmd == acf_pkg::DIGEST_GENERATION_CMD) ? `ACF_T_DIGEST_GEN_MS :
		(EXEC_CMD.cmd == acf_pkg::HMAC_RESP_CMD) ? `ACF_T_HMAC_RESP_MS :
		(EXEC_CMD.cmd == acf_pkg::MAC_VERIFY_CMD) ? `ACF_T_MAC_VERIFY_MS :
		(EXEC_CMD.cmd == acf_pkg::ZONE_LOCK_CMD) ? `ACF_T_ZONE_LOCK_MS :
		(EXEC_CMD.cmd == acf_pkg::MAC_RESP_CMD) ? `ACF_T_MAC_RESP_MS :
		(EXEC_CMD.cmd == acf_pkg::NONCE_GEN_CMD) ? `ACF_T_NONCE_GEN_MS :
		(EXEC_CMD.cmd == acf_pkg::IDLE_SELECT_CMD) ? `ACF_T_IDLE_SELECT_MS :
		(EXEC_CMD.cmd == acf_pkg::RANDOM_GEN_CMD) ? `ACF_T_RANDOM_GEN_MS :
		(EXEC_CMD.cmd == acf_pkg::WORD_READ_CMD) ? `ACF_T_WORD_READ_MS :
		(EXEC_CMD.cmd == acf_pkg::WORD_WRITE_CMD) ? `ACF_T_WORD_WRITE_MS :
		`ACF_T_EXTRA_UPDATE_MS;
	wire [31:0] lim_cyc = 32'(lim_ms * CYC_PER_MS);
	wire lim_hit = in_exec && (lim_r == lim_cyc - 32'h1);

	// checks after the last byte; crc first, parse order otherwise free
	wire chk_comm = crc_bad_r;
	wire chk_parse = (cnt_r < `ACF_CNT_CMD_MIN) || (dec_cmd == acf_pkg::UNKNOWN_CMD);

	// response select: one code for the shared buffer
	wire [7:0] resp_code =
		in_sleep ? `ACF_ST_WAKE :
		in_check ? (chk_comm ? `ACF_ST_COMM : `ACF_ST_PARSE) :
		EXEC_DONE ? EXEC_STATUS : `ACF_ST_EXEC;
	wire resp_load = !wdog_exp && ((in_sleep && wake_rise) ||
		(in_check && (chk_comm || chk_parse)) || (in_exec && (EXEC_DONE || lim_hit)));

	// response checksum over count and status
	wire [15:0] tx_crc_a;
	wire [15:0] tx_crc_b;
	acf_crc16_byte u_tx_crc_cnt (
		.crc_in(`ACF_CRC_INIT),
		.data_in(`ACF_CNT_STATUS),
		.crc_out(tx_crc_a)
	);
	acf_crc16_byte u_tx_crc_st (
		.crc_in(tx_crc_a),
		.data_in(resp_code),
		.crc_out(tx_crc_b)
	);

	// next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			acf_pkg::ST_SLEEP: begin
				if (wake_rise) begin
					st_nxt = acf_pkg::ST_IDLE;
				end
			end
			acf_pkg::ST_IDLE: begin
				if (rx_evt) begin
					st_nxt = cnt_bad ? acf_pkg::ST_CHECK : acf_pkg::ST_RECV;
				end
			end
			acf_pkg::ST_RECV: begin
				if (blk_done) begin
					st_nxt = acf_pkg::ST_CHECK;
				end else if (gap_exp) begin
					st_nxt = acf_pkg::ST_SLEEP;
				end else if (i2c_mode && ss_evt) begin
					st_nxt = acf_pkg::ST_IDLE;
				end
			end
			acf_pkg::ST_CHECK: begin
				st_nxt = (chk_comm || chk_parse) ? acf_pkg::ST_IDLE : acf_pkg::ST_EXEC;
			end
			acf_pkg::ST_EXEC: begin
				if (EXEC_DONE || lim_hit) begin
					st_nxt = acf_pkg::ST_IDLE;
				end
			end
		endcase
		if (wdog_exp) begin
			st_nxt = acf_pkg::ST_SLEEP;
		end
	end
	wire nxt_sleep = (st_nxt == acf_pkg::ST_SLEEP);
	wire outv_nxt = !nxt_sleep && (resp_load || outv_r);
	wire go_exec = in_check && (st_nxt == acf_pkg::ST_EXEC);

	// state and timers
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			st_r <= acf_pkg::ST_SLEEP;
			wdog_r <= 32'h0;
			gap_r <= 32'h0;
			lim_r <= 32'h0;
		end else begin
			st_r <= st_nxt;
			wdog_r <= in_sleep ? 32'h0 : wdog_r + 32'h1;
			gap_r <= (!in_recv || rx_evt) ? 32'h0 : gap_r + 32'h1;
			lim_r <= in_exec ? lim_r + 32'h1 : 32'h0;
		end
	end

	// block capture
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			idx_r <= 7'h0;
			cnt_r <= 8'h00;
			crc_r <= `ACF_CRC_INIT;
			crc_lo_r <= 8'h00;
			crc_bad_r <= 1'b0;
			opc_r <= 8'h00;
			p1_r <= 8'h00;
			p2_r <= 16'h0000;
		end else if (in_idle && rx_evt) begin
			idx_r <= 7'h1;
			cnt_r <= rx_hold_r;
			crc_r <= rx_crc_out;
			crc_bad_r <= cnt_bad;
		end else if (in_recv && rx_evt) begin
			idx_r <= idx_r + 7'h1;
			if (in_packet) begin
				crc_r <= rx_crc_out;
				if (pos == 8'h01) opc_r <= rx_hold_r;
				if (pos == 8'h02) p1_r <= rx_hold_r;
				if (pos == 8'h03) p2_r[7:0] <= rx_hold_r;
				if (pos == 8'h04) p2_r[15:8] <= rx_hold_r;
			end
			if (at_crc_lo) crc_lo_r <= rx_hold_r;
			if (blk_done) crc_bad_r <= ({rx_hold_r, crc_lo_r} != crc_r);
		end
	end

	// shared output buffer and link levels
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			outb_r <= '0;
			outv_r <= 1'b0;
			busy_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			if (resp_load) begin
				outb_r <= {tx_crc_b[15:8], tx_crc_b[7:0], resp_code, `ACF_CNT_STATUS};
			end
			outv_r <= outv_nxt;
			busy_r <= (st_nxt == acf_pkg::ST_CHECK) || (st_nxt == acf_pkg::ST_EXEC);
			ready_r <= (st_nxt == acf_pkg::ST_IDLE) && outv_nxt;
		end
	end

	// datapath request and power state
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			EXEC_REQ <= 1'b0;
			EXEC_CMD <= '0;
			ASLEEP <= 1'b1;
		end else begin
			EXEC_REQ <= go_exec || (EXEC_REQ && st_nxt == acf_pkg::ST_EXEC);
			if (go_exec) begin
				EXEC_CMD <= '{dec_cmd, opc_r, p1_r, p2_r};
			end
			ASLEEP <= nxt_sleep;
		end
	end

	// wake loads the wake status block
	wake_status_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_sleep && wake_rise && !wdog_exp |=> outv_r && outb_r.status == 8'h11
			&& outb_r.count == 8'h04 && in_idle)
		else $error("wake did not load status 0x11");
	// full block leads to busy check
	block_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		blk_done && !wdog_exp |=> in_check && busy_r)
		else $error("complete block did not go busy");
	// crc failure wins
	crc_first_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_check && crc_bad_r && !wdog_exp |=> outb_r.status == 8'hFF && !EXEC_REQ)
		else $error("crc error not reported first");
	// short block never executes
	short_parse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_check && !crc_bad_r && cnt_r < 8'h07 && !wdog_exp
			|=> outb_r.status == 8'h03 && !EXEC_REQ)
		else $error("short block not refused");
	// byte gap sleeps single-wire
	gap_sleep_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_recv && !i2c_mode && !rx_evt && gap_r == 32'(BYTE_GAP_CYC - 1) |=> in_sleep && ASLEEP)
		else $error("byte gap did not sleep");
	// i2c start or stop abandons block
	i2c_abort_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_recv && i2c_mode && ss_evt && !rx_evt && !wdog_exp |=> in_idle)
		else $error("start/stop did not end block");
	// watchdog forces sleep
	wdog_sleep_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!in_sleep && wdog_r == 32'(AWAKE_LIMIT_CYC - 1) |=> in_sleep && !outv_r ##1 ASLEEP)
		else $error("watchdog did not sleep");
	// busy limit gives execution error
	exec_limit_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_exec && !EXEC_DONE && lim_r == lim_cyc - 32'h1 && !wdog_exp
			|=> outb_r.status == 8'h0F && !EXEC_REQ)
		else $error("busy limit did not end command");
	// datapath status is returned
	exec_status_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_exec && EXEC_DONE && !wdog_exp |=> outb_r.status == $past(EXEC_STATUS) && ready_r)
		else $error("datapath status not returned");
	// reads refused mid block
	recv_noread_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		in_recv |-> !ready_r)
		else $error("read allowed mid block");
	// key derivation decode
	key_decode_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		go_exec && opc_r == 8'h1C |=> EXEC_CMD.cmd == acf_pkg::KEY_DERIVATION_CMD
			&& lim_cyc == 32'(62 * CYC_PER_MS))
		else $error("key derivation decode wrong");
	// busy link refuses reads
	busy_read_a: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
		LINK_RD_REQ && busy_s |=> LINK_RD_NAK && !LINK_RD_ACK)
		else $error("busy device answered a read");
endmodule
`default_nettype wire

// *** verilog/acf_pkg.sv ***
// acf_pkg.sv: types of the authentication command front end
`default_nettype none
package acf_pkg;
	// decoded command set
	typedef enum logic [3:0] {
		UNKNOWN_CMD, KEY_DERIVATION_CMD, REVISION_QUERY_CMD, DIGEST_GENERATION_CMD,
		HMAC_RESP_CMD, MAC_VERIFY_CMD, ZONE_LOCK_CMD, MAC_RESP_CMD, NONCE_GEN_CMD,
		IDLE_SELECT_CMD, RANDOM_GEN_CMD, WORD_READ_CMD, WORD_WRITE_CMD,
		CONFIG_EXTRA_UPDATE_CMD
	} acf_cmd_t;
	// core sequencer states
	typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_RECV, ST_CHECK, ST_EXEC} acf_state_t;
	// command handed to the datapaths
	typedef struct packed {
		acf_cmd_t cmd;
		logic [7:0] opcode;
		logic [7:0] first_parameter;
		logic [15:0] second_parameter;
	} acf_exec_t;
	// 4-byte response block, count in the low byte
	typedef struct packed {
		logic [7:0] crc_hi;
		logic [7:0] crc_lo;
		logic [7:0] status;
		logic [7:0] count;
	} acf_block_t;
endpackage
`default_nettype wire
